// ---- src/uotg_regs.svh ----
// Register map, field positions, reset values and timing of the OTG status block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
`ifndef UOTG_REGS_SVH
`define UOTG_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define UOTG_OFS_FLAGS   4'h0
`define UOTG_OFS_ENABLES 4'h4
`define UOTG_OFS_STATUS  4'h8

// ****************************************
// Bit positions, shared by flags and enables
// ****************************************
`define UOTG_B_ID   7
`define UOTG_B_TICK 6
`define UOTG_B_LINE 5
`define UOTG_B_ACT  4
`define UOTG_B_SESV 3
`define UOTG_B_SEND 2
`define UOTG_B_AVB  0

// ****************************************
// Masks and reset values
// ****************************************
`define UOTG_EVT_MASK  8'hFD
`define UOTG_STAT_MASK 8'hAD
`define UOTG_RST8      8'h00
`define UOTG_RST32     32'h0000_0000
`define UOTG_BE_LOW    4'h1

// ****************************************
// Timing
// ****************************************
`define UOTG_TICK_NS 1000000
`define UOTG_CLK_NS  40
`define UOTG_CNT_W   20

`endif

// ---- src/uotg_pkg.sv ----
// Types of the OTG status and interrupt block.
// Assumes uotg_regs.svh supplies the counter width.
`include "uotg_regs.svh"

package uotg_pkg;

  // One-hot states of the register bus slave.
  typedef enum logic [1:0] {
    UOTG_IDLE = 2'b01,
    UOTG_ACK  = 2'b10
  } uotg_bus_t;

  typedef struct packed {
    uotg_bus_t              bus;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic                   irq;
    logic [7:0]             flags;
    logic [7:0]             enables;
    logic                   primed;
    logic                   id;
    logic                   sesv;
    logic                   send;
    logic                   avb;
    logic                   se0;
    logic                   jst;
    logic                   line_stable;
    logic [1:0]             last_line;
    logic [`UOTG_CNT_W-1:0] line_cnt;
    logic [`UOTG_CNT_W-1:0] tick_cnt;
  } uotg_state_t;

endpackage : uotg_pkg

// ---- src/uotg_status_irq.sv ----
// OTG event flags, enables, line and VBUS status, one interrupt output.
// Assumes all inputs are synchronous to core_clk and an Avalon-MM master.
`timescale 1ns/1ps
`include "uotg_regs.svh"

module uotg_status_irq #(
  parameter int unsigned MS_CYCLES = `UOTG_TICK_NS / `UOTG_CLK_NS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Cable, line and comparators
  input  wire logic        cable_id_pin,
  input  wire logic        se0_line,
  input  wire logic        j_line_indication,
  input  wire logic        vbus_sess_valid,
  input  wire logic        vbus_sess_end,
  input  wire logic        vbus_a_valid,
  input  wire logic        bus_suspended,
  // Interrupt
  output logic             otg_irq
);
  import uotg_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  // The counters are fixed width, so the period must fit and leave room
  // for the terminal count compare.
  if (MS_CYCLES < 2 || MS_CYCLES >= (1 << `UOTG_CNT_W)) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end

  localparam logic [`UOTG_CNT_W-1:0] LAST_CNT = `UOTG_CNT_W'(MS_CYCLES - 1);

  // ****************************************
  // Helpers
  // ****************************************
  // Decodes a byte offset to one of the three register words.
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // Set wins over clear: a bit is kept unless written with one, and any
  // event in the same cycle sets it again.
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] clr,
                                     input logic [7:0] set);
    logic [7:0] res;
    res = `UOTG_RST8;
    for (int i = 0; i < 8; i++) begin
      res[i] = (cur[i] & ~clr[i]) | set[i];
    end
    w1c = res & `UOTG_EVT_MASK;
  endfunction : w1c

  uotg_state_t st_reg;
  uotg_state_t st_next;

  logic       req;
  logic       accept;
  logic       wr_lane;
  logic [7:0] events;
  logic [7:0] clr;
  logic [7:0] status;
  logic [1:0] line_now;
  logic       line_moved;
  logic       pins_moved;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next    = st_reg;
    req        = avs_read | avs_write;
    accept     = (st_reg.bus == UOTG_ACK);
    wr_lane    = (avs_byteenable & `UOTG_BE_LOW) != 4'h0;
    line_now   = {se0_line, j_line_indication};
    line_moved = (line_now != {st_reg.se0, st_reg.jst});
    pins_moved = line_moved | (cable_id_pin != st_reg.id)
               | (vbus_sess_valid != st_reg.sesv)
               | (vbus_sess_end != st_reg.send)
               | (vbus_a_valid != st_reg.avb);
    events     = `UOTG_RST8;
    clr        = `UOTG_RST8;

    // Samples of the pins; the first cycle after reset only primes them so
    // that a pin already high at reset raises no change event.
    st_next.primed = 1'b1;
    st_next.id     = cable_id_pin;
    st_next.sesv   = vbus_sess_valid;
    st_next.send   = vbus_sess_end;
    st_next.avb    = vbus_a_valid;
    st_next.se0    = se0_line;
    st_next.jst    = j_line_indication;

    if (st_reg.primed) begin
      events[`UOTG_B_ID]   = cable_id_pin != st_reg.id;
      events[`UOTG_B_SESV] = vbus_sess_end & ~st_reg.send;
      events[`UOTG_B_SEND] = vbus_sess_end != st_reg.send;
      events[`UOTG_B_AVB]  = vbus_sess_valid != st_reg.sesv;
      events[`UOTG_B_ACT]  = bus_suspended & pins_moved;
    end

    // Free-running millisecond timer.
    if (st_reg.tick_cnt == LAST_CNT) begin
      st_next.tick_cnt      = '0;
      events[`UOTG_B_TICK]  = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end

    // Line state stability: any movement restarts the window; reaching its
    // end marks the line stable and reports a new stable value once.
    if (line_moved) begin
      st_next.line_cnt    = '0;
      st_next.line_stable = 1'b0;
    end else if (!st_reg.line_stable) begin
      if (st_reg.line_cnt == LAST_CNT) begin
        st_next.line_stable = 1'b1;
        st_next.last_line   = line_now;
        events[`UOTG_B_LINE] = line_now != st_reg.last_line;
      end else begin
        st_next.line_cnt = st_reg.line_cnt + 1'b1;
      end
    end

    status = {st_reg.id, 1'b0, st_reg.line_stable, 1'b0,
              st_reg.sesv, st_reg.send, 1'b0, st_reg.avb} & `UOTG_STAT_MASK;

    // Bus slave: one wait cycle, then the answer stands for one edge.
    st_next.bus     = UOTG_IDLE;
    st_next.waitreq = 1'b1;
    if (req && !accept) begin
      st_next.bus     = UOTG_ACK;
      st_next.waitreq = 1'b0;
      st_next.rdata   = `UOTG_RST32;
      if (avs_read) begin
        if (hit(avs_address, `UOTG_OFS_FLAGS)) begin
          st_next.rdata[7:0] = st_reg.flags;
        end else if (hit(avs_address, `UOTG_OFS_ENABLES)) begin
          st_next.rdata[7:0] = st_reg.enables;
        end else if (hit(avs_address, `UOTG_OFS_STATUS)) begin
          st_next.rdata[7:0] = status;
        end
      end
    end

    // Writes take effect at the edge where waitrequest is seen low.
    if (accept && avs_write && wr_lane) begin
      if (hit(avs_address, `UOTG_OFS_FLAGS)) begin
        clr = avs_writedata[7:0];
      end
      if (hit(avs_address, `UOTG_OFS_ENABLES)) begin
        st_next.enables = avs_writedata[7:0] & `UOTG_EVT_MASK;
      end
    end

    st_next.flags = w1c(st_reg.flags, clr, events);
    st_next.irq   = |(st_next.flags & st_next.enables);

    if (srst) begin
      st_next             = '0;
      st_next.bus         = UOTG_IDLE;
      st_next.waitreq     = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign otg_irq         = st_reg.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_wait;
    req && st_reg.waitreq;
  endsequence

  sequence s_ack;
    !st_reg.waitreq ##1 st_reg.waitreq;
  endsequence

  a_bus_ack_one: assert property (s_wait |=> s_ack)
    else $error("waitrequest did not answer in one cycle");

  a_flag_sticky: assert property (
    !(accept && avs_write && hit(avs_address, `UOTG_OFS_FLAGS))
    |=> ((st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags)))
    else $error("flag lost without a clear");

  a_flag_clear: assert property (
    accept && avs_write && wr_lane && hit(avs_address, `UOTG_OFS_FLAGS)
    && avs_writedata[`UOTG_B_ID] && !events[`UOTG_B_ID]
    |=> !st_reg.flags[`UOTG_B_ID])
    else $error("write one did not clear flag");

  a_id_change: assert property (
    st_reg.primed && cable_id_pin != st_reg.id |=> st_reg.flags[`UOTG_B_ID])
    else $error("id change not flagged");

  a_tick_flag: assert property (
    st_reg.tick_cnt == LAST_CNT |=> st_reg.flags[`UOTG_B_TICK] && st_reg.tick_cnt == '0)
    else $error("millisecond tick not flagged");

  a_line_stable: assert property (
    $rose(st_reg.flags[`UOTG_B_LINE]) |-> st_reg.line_stable)
    else $error("line flag without stable line");

  a_sess_end: assert property (
    st_reg.primed && vbus_sess_end && !st_reg.send
    |=> st_reg.flags[`UOTG_B_SESV] && st_reg.flags[`UOTG_B_SEND])
    else $error("session end fall not flagged");

  a_bit1_zero: assert property (
    !st_reg.enables[1] && !st_reg.flags[1])
    else $error("bit 1 became set");

  a_stat_upper: assert property (
    st_reg.rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  a_irq_follow: assert property (
    ##1 otg_irq == |($past(st_next.flags) & $past(st_next.enables)))
    else $error("interrupt does not follow enabled flags");

  a_status_id: assert property (
    ##1 st_reg.id == $past(cable_id_pin))
    else $error("id status does not follow pin");

  // ****************************************
  // Event, status and interrupt assertions
  // ****************************************
  // The change detectors only arm once the pin samples are primed, so those
  // antecedents carry st_reg.primed; the first cycle after reset deliberately
  // raises no change flag even when a pin already sits high.

  sequence s_send_moves;
    st_reg.primed && (vbus_sess_end != st_reg.send);
  endsequence

  sequence s_sesv_moves;
    st_reg.primed && (vbus_sess_valid != st_reg.sesv);
  endsequence

  sequence s_asleep_moves;
    st_reg.primed && bus_suspended && pins_moved;
  endsequence

  sequence s_line_settles;
    !line_moved && !st_reg.line_stable && (st_reg.line_cnt == LAST_CNT);
  endsequence

  a_send_change: assert property (s_send_moves |=> st_reg.flags[`UOTG_B_SEND])
    else $error("session end change not flagged");

  a_avb_change: assert property (s_sesv_moves |=> st_reg.flags[`UOTG_B_AVB])
    else $error("session valid change not flagged");

  a_act_wake: assert property (s_asleep_moves |=> st_reg.flags[`UOTG_B_ACT])
    else $error("wake-up activity not flagged");

  a_line_new: assert property (
    s_line_settles ##0 (line_now != st_reg.last_line)
    |=> st_reg.flags[`UOTG_B_LINE] && st_reg.line_stable)
    else $error("new stable line state not flagged");

  a_line_same: assert property (
    s_line_settles ##0 (line_now == st_reg.last_line)
    |=> !$rose(st_reg.flags[`UOTG_B_LINE]) && st_reg.line_stable)
    else $error("unchanged stable line state flagged");

  a_line_drop: assert property (
    line_moved |=> !st_reg.line_stable && (st_reg.line_cnt == '0))
    else $error("line stable kept after a line change");

  a_line_count: assert property (
    st_reg.line_stable |-> (st_reg.line_cnt == LAST_CNT))
    else $error("line marked stable before the full window");

  a_en_write: assert property (
    accept && avs_write && wr_lane && hit(avs_address, `UOTG_OFS_ENABLES)
    |=> st_reg.enables == ($past(avs_writedata[7:0]) & `UOTG_EVT_MASK))
    else $error("enable write not taken");

  a_en_keep: assert property (
    !(accept && avs_write && hit(avs_address, `UOTG_OFS_ENABLES))
    |=> st_reg.enables == $past(st_reg.enables))
    else $error("enables changed without a write");

  a_zero_write: assert property (
    accept && avs_write && hit(avs_address, `UOTG_OFS_FLAGS)
    && (!wr_lane || avs_writedata[7:0] == `UOTG_RST8)
    |=> ((st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags)))
    else $error("flag lost on a write of zero");

  a_flag_read: assert property (
    req && st_reg.waitreq && avs_read && hit(avs_address, `UOTG_OFS_FLAGS)
    |=> avs_readdata == {24'h00_0000, $past(st_reg.flags)})
    else $error("flag read does not show the flags");

  a_stat_read: assert property (
    req && st_reg.waitreq && avs_read && hit(avs_address, `UOTG_OFS_STATUS)
    |=> avs_readdata == {24'h00_0000, $past(status)})
    else $error("status read does not show the pin samples");

  a_unused_zero: assert property (
    (avs_readdata[7:0] & ~`UOTG_EVT_MASK) == `UOTG_RST8)
    else $error("unimplemented bit 1 read as one");

  a_id_quiet: assert property (
    (cable_id_pin == st_reg.id) && !st_reg.flags[`UOTG_B_ID]
    |=> !st_reg.flags[`UOTG_B_ID])
    else $error("id flag set without an id change");

  a_sesv_quiet: assert property (
    !(vbus_sess_end && !st_reg.send) && !st_reg.flags[`UOTG_B_SESV]
    |=> !st_reg.flags[`UOTG_B_SESV])
    else $error("session flag set without a fall below session end");

  a_stat_pins: assert property (
    ##1 st_reg.sesv == $past(vbus_sess_valid) && st_reg.send == $past(vbus_sess_end)
    && st_reg.avb == $past(vbus_a_valid))
    else $error("vbus status does not follow comparators");

  a_irq_idle: assert property (
    (st_reg.flags & st_reg.enables) == `UOTG_RST8 |-> !otg_irq)
    else $error("interrupt raised with no enabled flag");

  a_irq_tick: assert property (
    st_reg.flags[`UOTG_B_TICK] && st_reg.enables[`UOTG_B_TICK] |-> otg_irq)
    else $error("enabled millisecond flag gives no interrupt");

  a_tick_step: assert property (
    st_reg.tick_cnt != '0 |-> st_reg.tick_cnt == $past(st_reg.tick_cnt) + 1'b1)
    else $error("millisecond counter skipped a step");

endmodule : uotg_status_irq

// ---- testbench/uotg_far_side.sv ----
// Model of the cable, transceiver and VBUS comparators seen by the OTG status block.
// Assumes the bench sets wanted levels right after a rising edge of core_clk.
`timescale 1ns/1ps

module uotg_far_side (
  // Clock
  input  wire logic       core_clk,
  // Wanted levels {id, se0, j, sess_valid, sess_end, a_valid, suspended} and speed
  input  wire logic [6:0] want,
  input  wire logic       slow,
  // Pins
  output logic            cable_id_pin,
  output logic            se0_line,
  output logic            j_line_indication,
  output logic            vbus_sess_valid,
  output logic            vbus_sess_end,
  output logic            vbus_a_valid,
  output logic            bus_suspended
);
  logic [6:0] lag_reg;

  // The USB clock itself is not modelled; levels move on the system clock edge.
  // Slow mode adds one cycle, as a comparator with a longer settling time would.
  always_ff @(posedge core_clk) begin
    lag_reg <= want;
    {cable_id_pin, se0_line, j_line_indication, vbus_sess_valid, vbus_sess_end, vbus_a_valid,
     bus_suspended} <= slow ? lag_reg : want;
  end
endmodule : uotg_far_side

// ---- testbench/tb_top.sv ----
// Register-level bench for the OTG status and interrupt block.
// Assumes the far-side model drives every pin and an 8-cycle millisecond.
`timescale 1ns/1ps
`include "uotg_regs.svh"

module tb_top;
  import uotg_pkg::*;
  logic        core_clk, srst, avs_read, avs_write, avs_waitrequest, otg_irq, slow;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        cable_id_pin, se0_line, j_line_indication, vbus_sess_valid;
  logic        vbus_sess_end, vbus_a_valid, bus_suspended;
  logic [6:0]  want;
  int          miscompares, compares, n;
  logic [6:0]  ev [5] = '{7'b1000000, 7'b1000100, 7'b1001100, 7'b0001101, 7'b0000001};
  logic [7:0]  fx [5] = '{8'h80, 8'h0C, 8'h01, 8'h90, 8'h15};

  // ****
  // Design and far side
  // ****
  uotg_status_irq #(.MS_CYCLES(8)) i_dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cable_id_pin(cable_id_pin), .se0_line(se0_line), .j_line_indication(j_line_indication),
    .vbus_sess_valid(vbus_sess_valid), .vbus_sess_end(vbus_sess_end), .vbus_a_valid(vbus_a_valid),
    .bus_suspended(bus_suspended), .otg_irq(otg_irq));
  uotg_far_side i_far (.core_clk(core_clk), .want(want), .slow(slow), .cable_id_pin(cable_id_pin),
    .se0_line(se0_line), .j_line_indication(j_line_indication), .vbus_sess_valid(vbus_sess_valid),
    .vbus_sess_end(vbus_sess_end), .vbus_a_valid(vbus_a_valid), .bus_suspended(bus_suspended));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ****
  // Tasks
  // ****
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The request is held until waitrequest is sampled low; that edge also takes the read data.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      end_sim();
    end
  endtask : bus

  // ****
  // Scenarios
  // ****
  initial begin
    {srst, avs_read, avs_write, slow} = 4'b1000;
    {avs_address, avs_byteenable, avs_writedata, want} = '0;
    miscompares = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    bus(0, `UOTG_OFS_FLAGS, 0, 4'hF);   check(q, 32'h0000_0000);
    bus(0, `UOTG_OFS_ENABLES, 0, 4'hF); check(q, 32'h0000_0000);
    bus(1, `UOTG_OFS_ENABLES, 32'hFFFF_FFFF, 4'hF);
    bus(0, `UOTG_OFS_ENABLES, 0, 4'hF); check(q, 32'h0000_00FD);
    bus(1, `UOTG_OFS_ENABLES, 0, 4'hF);
    want <= 7'b1001110;
    repeat (12) @(posedge core_clk);
    bus(0, `UOTG_OFS_STATUS, 0, 4'hF); check(q, 32'h0000_00AD);
    want <= 7'b0000000;
    repeat (12) @(posedge core_clk);
    bus(1, `UOTG_OFS_STATUS, 32'hFF, 4'hF);
    bus(0, `UOTG_OFS_STATUS, 0, 4'hF); check(q, 32'h0000_0020);
    for (int i = 0; i < 5; i++) begin
      want[0] <= ev[i][0];
      repeat (3) @(posedge core_clk);
      bus(1, `UOTG_OFS_FLAGS, 32'hFF, 4'hF);
      want[6:1] <= ev[i][6:1];
      repeat (3) @(posedge core_clk);
      bus(0, `UOTG_OFS_FLAGS, 0, 4'hF); check(q & 32'hBF, {24'h0, fx[i]});
      check(otg_irq, 1'b0);
    end
    want <= 7'b0010000;
    // The block sees a pin two edges after the model is told; read only then.
    repeat (2) @(posedge core_clk);
    bus(0, `UOTG_OFS_STATUS, 0, 4'hF); check(q & 32'h20, 32'h0);
    repeat (12) @(posedge core_clk);
    bus(0, `UOTG_OFS_FLAGS, 0, 4'hF);  check(q & 32'h20, 32'h20);
    bus(0, `UOTG_OFS_STATUS, 0, 4'hF); check(q & 32'h20, 32'h20);
    bus(1, `UOTG_OFS_FLAGS, 32'h00, 4'hF);
    bus(1, `UOTG_OFS_FLAGS, 32'h20, 4'h0);
    bus(0, `UOTG_OFS_FLAGS, 0, 4'hF); check(q & 32'h20, 32'h20);
    bus(1, `UOTG_OFS_FLAGS, 32'h20, 4'h1);
    bus(0, `UOTG_OFS_FLAGS, 0, 4'hF); check(q & 32'h20, 32'h0);
    bus(1, 4'hC, 32'hFF, 4'hF);
    bus(0, 4'hC, 0, 4'hF); check(q, 32'h0);
    bus(1, `UOTG_OFS_ENABLES, 32'h40, 4'hF);
    bus(1, `UOTG_OFS_FLAGS, 32'hFF, 4'hF);
    @(posedge core_clk);
    n = 0;
    while (otg_irq !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    check(otg_irq, 1'b1);
    bus(1, `UOTG_OFS_ENABLES, 32'h80, 4'hF);
    repeat (2) @(posedge core_clk);
    check(otg_irq, 1'b0);
    slow <= 1'b1;
    want[6] <= 1'b1;
    n = 0;
    while (otg_irq !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    check(otg_irq, 1'b1);
    bus(1, `UOTG_OFS_FLAGS, 32'h80, 4'hF);
    repeat (2) @(posedge core_clk);
    check(otg_irq, 1'b0);
    end_sim();
  end
endmodule : tb_top
